// ===== include/sso_consts.svh
`ifndef SSO_CONSTS_SVH
`define SSO_CONSTS_SVH

// object indices
`define SSO_IDX_QSTOP     16'h605A
`define SSO_IDX_SHUT      16'h605B
`define SSO_IDX_DIS       16'h605C
`define SSO_IDX_HALT      16'h605D
`define SSO_IDX_FAULT     16'h605E
`define SSO_IDX_MODE_REQ  16'h6060
`define SSO_IDX_MODE_SHOW 16'h6061
`define SSO_IDX_POS_CMD   16'h6062
`define SSO_IDX_POS_ENC   16'h6063
`define SSO_IDX_POS_USER  16'h6064
`define SSO_IDX_FE_LIMIT  16'h6065

// reset values
`define SSO_QSTOP_RST     16'h0002
`define SSO_SHUT_RST      16'h0000
`define SSO_DIS_RST       16'h0000
`define SSO_HALT_RST      16'h0001
`define SSO_FAULT_RST     16'h0000
`define SSO_MODE_RST      8'h08
`define SSO_FE_LIMIT_RST  32'h0000_7530

// operating mode codes
`define SSO_MODE_PPOS     8'h01
`define SSO_MODE_PVEL     8'h03
`define SSO_MODE_PTRQ     8'h04
`define SSO_MODE_HOME     8'h06
`define SSO_MODE_CPOS     8'h08
`define SSO_MODE_CVEL     8'h09
`define SSO_MODE_CTRQ     8'h0A

// option code limits and values
`define SSO_QSTOP_MAX     16'h0007
`define SSO_QSTOP_HOLE    16'h0004
`define SSO_QSTOP_STAY    16'h0005
`define SSO_SHUT_MAX      16'h0001
`define SSO_HALT_MIN      16'h0001
`define SSO_HALT_MAX      16'h0003
`define SSO_FAULT_MAX     16'h0002
`define SSO_CODE_0        16'h0000
`define SSO_CODE_1        16'h0001
`define SSO_CODE_2        16'h0002
`define SSO_CODE_3        16'h0003

`endif

// ===== include/sso_pkg.sv
package sso_pkg;

  typedef enum logic [3:0] {
    SSO_SRC_NONE    = 4'h0,
    SSO_SRC_PROFILE = 4'h1,
    SSO_SRC_QUICK   = 4'h2,
    SSO_SRC_THIRD   = 4'h3,
    SSO_SRC_HOMING  = 4'h4,
    SSO_SRC_TSLOPE  = 4'h5,
    SSO_SRC_EMERG   = 4'h6,
    SSO_SRC_COAST   = 4'h7,
    SSO_SRC_TZERO   = 4'h8
  } sso_src_t;

  typedef enum logic [2:0] {
    SSO_RES_NONE    = 3'h0,
    SSO_RES_SWON_DIS = 3'h1,
    SSO_RES_QSTOP   = 3'h2,
    SSO_RES_OP_EN   = 3'h3,
    SSO_RES_FAULT   = 3'h4,
    SSO_RES_MODE    = 3'h5
  } sso_result_t;

  typedef enum logic [1:0] {
    SSO_ST_IDLE = 2'b00,
    SSO_ST_RAMP = 2'b01,
    SSO_ST_HOLD = 2'b11
  } sso_state_t;

  typedef enum logic [1:0] {
    SSO_MC_LINEAR = 2'h0,
    SSO_MC_HOMING = 2'h1,
    SSO_MC_TORQUE = 2'h2
  } sso_mclass_t;

endpackage

// ===== rtl/sso_stop_ctrl.sv
`include "sso_consts.svh"

// Contract
// - quick-stop 1/2/3 use profile/quick/third decel, then disabled.
// - quick-stop 5/6/7 same sources, stay quick-stop.
// - quick-stop 0 uses stop method, then switch-on-disabled.
// - homing quick-stop 1/5 use homing acceleration.
// - shutdown 0 by stop method: 0 emergency, 1 coast.
// - shutdown 1: profile, homing or torque slope by mode.
// - disable code 0/1 encoded like shutdown.
// - halt 1..3, default 1, pick decel; stays enabled.
// - mode change ramps with halt-selected decel.
// - torque halt 1/2 slope, 3 zero torque.
// - fault 0..2 default 0: attribute, profile, quick; faulted.
// - homing fault 1 homing acc; torque 0/1 attribute, 2 slope.
// - drive alarms ignore code, stop by attribute, fault.
// - mode codes 1,3,4,6,8,9,10; request default 8.
// - active mode shown in 8-bit display object.
// - signed 32-bit position command, valid while enabled.
// - signed 32-bit read-only encoder position.
// - user position is encoder position over gear ratio.
// - following error above window, default 30000.
// - quick-stop request stops per code 0..7.
module sso_stop_ctrl #(
  parameter int SPD_W = 32
) (
  input  wire logic               core_clk_i,
  input  wire logic               resetn_i,
  input  wire logic               obj_req_i,
  input  wire logic               obj_we_i,
  input  wire logic [15:0]        obj_index_i,
  input  wire logic [31:0]        obj_wdata_i,
  input  wire logic               quick_stop_req_i,
  input  wire logic               halt_req_i,
  input  wire logic               shutdown_req_i,
  input  wire logic               disable_req_i,
  input  wire logic               fault_sel_i,
  input  wire logic               fault_drive_i,
  input  wire logic               alarm_coast_i,
  input  wire logic               stop_method_param_i,
  input  wire logic               release_i,
  input  wire logic               drive_enabled_i,
  input  wire logic [SPD_W-1:0]   speed_cmd_i,
  input  wire logic [SPD_W-1:0]   profile_decel_i,
  input  wire logic [SPD_W-1:0]   quick_decel_i,
  input  wire logic [SPD_W-1:0]   third_decel_i,
  input  wire logic [SPD_W-1:0]   homing_acc_i,
  input  wire logic [SPD_W-1:0]   torque_slope_i,
  input  wire logic [31:0]        pos_cmd_i,
  input  wire logic [31:0]        enc_pos_i,
  input  wire logic [15:0]        gear_ratio_i,
  output logic                    obj_ack_o,
  output logic                    obj_err_o,
  output logic [31:0]             obj_rdata_o,
  output sso_pkg::sso_src_t       decel_src_o,
  output sso_pkg::sso_result_t    end_state_o,
  output sso_pkg::sso_state_t     stop_state_o,
  output logic [SPD_W-1:0]        ramp_speed_o,
  output logic                    axis_enable_o,
  output logic                    coast_o,
  output logic                    torque_zero_o,
  output logic                    following_error_o
);
  import sso_pkg::*;

  if (SPD_W < 8 || SPD_W > 32) begin : g_chk
    $error("SPD_W not in 8..32");
  end

  logic              rst_meta_reg;
  logic              rst_sync_reg;
  logic [15:0]       qstop_code_reg;
  logic [15:0]       shut_code_reg;
  logic [15:0]       dis_code_reg;
  logic [15:0]       halt_code_reg;
  logic [15:0]       fault_code_reg;
  logic [7:0]        mode_req_reg;
  logic [7:0]        mode_show_reg;
  logic [31:0]       pos_cmd_reg;
  logic [31:0]       pos_enc_reg;
  logic [31:0]       pos_user_reg;
  logic [31:0]       pos_user_next;
  logic [31:0]       fe_limit_reg;
  logic [32:0]       fe_diff;
  logic [32:0]       fe_mag;
  sso_state_t        state_reg;
  sso_src_t          src_reg;
  sso_result_t       res_reg;
  logic [SPD_W-1:0]  ramp_reg;
  logic [SPD_W-1:0]  ramp_next;
  logic [SPD_W-1:0]  step;
  logic [SPD_W-1:0]  speed_mag;
  sso_mclass_t       mclass;
  logic              start;
  sso_src_t          start_src;
  sso_result_t       start_res;
  logic              fault_any;
  sso_src_t          fault_src;
  logic              wr_ok;
  logic [31:0]       rd_val;
  logic              rd_hit;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_comb begin
    case (mode_show_reg)
      `SSO_MODE_HOME: mclass = SSO_MC_HOMING;
      `SSO_MODE_PTRQ,
      `SSO_MODE_CTRQ: mclass = SSO_MC_TORQUE;
      default:        mclass = SSO_MC_LINEAR;
    endcase
  end

  function automatic sso_src_t method_src(input logic m);
    method_src = m ? SSO_SRC_COAST : SSO_SRC_EMERG;
  endfunction

  // base source per mode class
  function automatic sso_src_t base_src(input sso_mclass_t mc);
    case (mc)
      SSO_MC_HOMING: base_src = SSO_SRC_HOMING;
      SSO_MC_TORQUE: base_src = SSO_SRC_TSLOPE;
      default:       base_src = SSO_SRC_PROFILE;
    endcase
  endfunction

  function automatic sso_src_t qstop_src(input logic [15:0] c,
                                         input sso_mclass_t mc,
                                         input logic m);
    case (c)
      `SSO_CODE_0: qstop_src = method_src(m);
      16'h0001, 16'h0005:
        qstop_src = (mc == SSO_MC_HOMING) ? SSO_SRC_HOMING
                                          : SSO_SRC_PROFILE;
      16'h0002, 16'h0006: qstop_src = SSO_SRC_QUICK;
      16'h0003, 16'h0007: qstop_src = SSO_SRC_THIRD;
      default: qstop_src = SSO_SRC_QUICK;
    endcase
  endfunction

  function automatic sso_src_t shut_src(input logic [15:0] c,
                                        input sso_mclass_t mc,
                                        input logic m);
    if (c == `SSO_CODE_0) begin
      shut_src = method_src(m);
    end else begin
      shut_src = base_src(mc);
    end
  endfunction

  function automatic sso_src_t halt_src(input logic [15:0] c,
                                        input sso_mclass_t mc);
    if (mc == SSO_MC_TORQUE) begin
      halt_src = (c == `SSO_CODE_3) ? SSO_SRC_TZERO
                                    : SSO_SRC_TSLOPE;
    end else begin
      case (c)
        `SSO_CODE_2: halt_src = SSO_SRC_QUICK;
        `SSO_CODE_3: halt_src = SSO_SRC_THIRD;
        default:     halt_src = base_src(mc);
      endcase
    end
  endfunction

  function automatic sso_src_t flt_src(input logic [15:0] c,
                                       input sso_mclass_t mc,
                                       input logic a);
    if (mc == SSO_MC_TORQUE) begin
      flt_src = (c == `SSO_CODE_2) ? SSO_SRC_TSLOPE : method_src(a);
    end else begin
      case (c)
        `SSO_CODE_1: flt_src = base_src(mc);
        `SSO_CODE_2: flt_src = SSO_SRC_QUICK;
        default:     flt_src = method_src(a);
      endcase
    end
  endfunction

  // drive-side alarms ignore the code
  always_comb begin
    fault_any = fault_sel_i | fault_drive_i;
    if (fault_drive_i) begin
      fault_src = method_src(alarm_coast_i);
    end else begin
      fault_src = flt_src(fault_code_reg, mclass, alarm_coast_i);
    end
  end

  // request priority: fault, quick stop, disable, shutdown, halt, mode
  always_comb begin
    start     = 1'b0;
    start_src = SSO_SRC_NONE;
    start_res = SSO_RES_NONE;
    if (fault_any) begin
      start     = 1'b1;
      start_src = fault_src;
      start_res = SSO_RES_FAULT;
    end else if (quick_stop_req_i) begin
      start     = 1'b1;
      start_src = qstop_src(qstop_code_reg, mclass,
                            stop_method_param_i);
      start_res = (qstop_code_reg >= `SSO_QSTOP_STAY) ? SSO_RES_QSTOP
                                                      : SSO_RES_SWON_DIS;
    end else if (disable_req_i) begin
      start     = 1'b1;
      start_src = shut_src(dis_code_reg, mclass,
                           stop_method_param_i);
      start_res = SSO_RES_SWON_DIS;
    end else if (shutdown_req_i) begin
      start     = 1'b1;
      start_src = shut_src(shut_code_reg, mclass,
                           stop_method_param_i);
      start_res = SSO_RES_SWON_DIS;
    end else if (halt_req_i) begin
      start     = 1'b1;
      start_src = halt_src(halt_code_reg, mclass);
      start_res = SSO_RES_OP_EN;
    end else if (mode_req_reg != mode_show_reg) begin
      start     = 1'b1;
      start_src = halt_src(halt_code_reg, mclass);
      start_res = SSO_RES_MODE;
    end
  end

  always_comb begin
    case (src_reg)
      SSO_SRC_PROFILE: step = profile_decel_i;
      SSO_SRC_QUICK:   step = quick_decel_i;
      SSO_SRC_THIRD:   step = third_decel_i;
      SSO_SRC_HOMING:  step = homing_acc_i;
      SSO_SRC_TSLOPE:  step = torque_slope_i;
      default:         step = '1;
    endcase
    // zero rate still steps by one
    if (ramp_reg <= step || step == '0 && ramp_reg <= 1'b1) begin
      ramp_next = '0;
    end else if (step == '0) begin
      ramp_next = ramp_reg - 1'b1;
    end else begin
      ramp_next = ramp_reg - step;
    end
    speed_mag = speed_cmd_i[SPD_W-1] ? SPD_W'(-speed_cmd_i) : speed_cmd_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= SSO_ST_IDLE;
      src_reg   <= SSO_SRC_NONE;
      res_reg   <= SSO_RES_NONE;
      ramp_reg  <= '0;
    end else begin
      case (state_reg)
        SSO_ST_IDLE: begin
          if (start) begin
            state_reg <= SSO_ST_RAMP;
            src_reg   <= start_src;
            res_reg   <= start_res;
            ramp_reg  <= speed_mag;
          end
        end
        SSO_ST_RAMP: begin
          if (fault_any && res_reg != SSO_RES_FAULT) begin
            src_reg <= fault_src;
            res_reg <= SSO_RES_FAULT;
            ramp_reg <= ramp_next;
          end else if (ramp_reg == '0) begin
            state_reg <= (res_reg == SSO_RES_MODE) ? SSO_ST_IDLE
                                                   : SSO_ST_HOLD;
          end else begin
            ramp_reg <= ramp_next;
          end
        end
        SSO_ST_HOLD: begin
          if (fault_any && res_reg != SSO_RES_FAULT) begin
            state_reg <= SSO_ST_RAMP;
            src_reg   <= fault_src;
            res_reg   <= SSO_RES_FAULT;
          end else if (res_reg == SSO_RES_OP_EN ? !halt_req_i
                                                : release_i) begin
            state_reg <= SSO_ST_IDLE;
            src_reg   <= SSO_SRC_NONE;
            res_reg   <= SSO_RES_NONE;
          end
        end
        default: state_reg <= SSO_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      decel_src_o   <= SSO_SRC_NONE;
      end_state_o   <= SSO_RES_NONE;
      stop_state_o  <= SSO_ST_IDLE;
      ramp_speed_o  <= '0;
      axis_enable_o <= 1'b0;
      coast_o       <= 1'b0;
      torque_zero_o <= 1'b0;
    end else begin
      decel_src_o   <= src_reg;
      stop_state_o  <= state_reg;
      ramp_speed_o  <= ramp_reg;
      coast_o       <= (state_reg != SSO_ST_IDLE) &&
                       (src_reg == SSO_SRC_COAST);
      torque_zero_o <= (state_reg != SSO_ST_IDLE) &&
                       (src_reg == SSO_SRC_TZERO);
      end_state_o   <= (state_reg == SSO_ST_HOLD) ? res_reg : SSO_RES_NONE;
      case (state_reg)
        SSO_ST_HOLD:
          axis_enable_o <= (res_reg == SSO_RES_OP_EN) ||
                           (res_reg == SSO_RES_QSTOP);
        SSO_ST_RAMP:
          axis_enable_o <= (src_reg != SSO_SRC_COAST);
        default:
          axis_enable_o <= drive_enabled_i;
      endcase
    end
  end

  // display takes the request after the ramp
  always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mode_show_reg <= `SSO_MODE_RST;
    end else if (state_reg == SSO_ST_RAMP && res_reg == SSO_RES_MODE &&
                 ramp_reg == '0) begin
      mode_show_reg <= mode_req_reg;
    end else if (obj_req_i && obj_we_i && wr_ok &&
                 obj_index_i == `SSO_IDX_MODE_SHOW) begin
      mode_show_reg <= obj_wdata_i[7:0];
    end
  end

  function automatic logic mode_ok(input logic [7:0] m);
    case (m)
      `SSO_MODE_PPOS, `SSO_MODE_PVEL, `SSO_MODE_PTRQ, `SSO_MODE_HOME,
      `SSO_MODE_CPOS, `SSO_MODE_CVEL, `SSO_MODE_CTRQ: mode_ok = 1'b1;
      default: mode_ok = 1'b0;
    endcase
  endfunction

  always_comb begin
    case (obj_index_i)
      `SSO_IDX_QSTOP: wr_ok = obj_wdata_i[15:0] <= `SSO_QSTOP_MAX &&
                              obj_wdata_i[15:0] != `SSO_QSTOP_HOLE;
      `SSO_IDX_SHUT,
      `SSO_IDX_DIS:   wr_ok = obj_wdata_i[15:0] <= `SSO_SHUT_MAX;
      `SSO_IDX_HALT:  wr_ok = obj_wdata_i[15:0] >= `SSO_HALT_MIN &&
                              obj_wdata_i[15:0] <= `SSO_HALT_MAX;
      `SSO_IDX_FAULT: wr_ok = obj_wdata_i[15:0] <= `SSO_FAULT_MAX;
      `SSO_IDX_MODE_REQ,
      `SSO_IDX_MODE_SHOW: wr_ok = mode_ok(obj_wdata_i[7:0]);
      default:        wr_ok = 1'b0;
    endcase
    rd_hit = 1'b1;
    case (obj_index_i)
      `SSO_IDX_QSTOP:     rd_val = {16'h0000, qstop_code_reg};
      `SSO_IDX_SHUT:      rd_val = {16'h0000, shut_code_reg};
      `SSO_IDX_DIS:       rd_val = {16'h0000, dis_code_reg};
      `SSO_IDX_HALT:      rd_val = {16'h0000, halt_code_reg};
      `SSO_IDX_FAULT:     rd_val = {16'h0000, fault_code_reg};
      `SSO_IDX_MODE_REQ:  rd_val = {24'h000000, mode_req_reg};
      `SSO_IDX_MODE_SHOW: rd_val = {24'h000000, mode_show_reg};
      `SSO_IDX_POS_CMD:   rd_val = pos_cmd_reg;
      `SSO_IDX_POS_ENC:   rd_val = pos_enc_reg;
      `SSO_IDX_POS_USER:  rd_val = pos_user_reg;
      `SSO_IDX_FE_LIMIT:  rd_val = fe_limit_reg;
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      qstop_code_reg <= `SSO_QSTOP_RST;
      shut_code_reg  <= `SSO_SHUT_RST;
      dis_code_reg   <= `SSO_DIS_RST;
      halt_code_reg  <= `SSO_HALT_RST;
      fault_code_reg <= `SSO_FAULT_RST;
      mode_req_reg   <= `SSO_MODE_RST;
    end else if (obj_req_i && obj_we_i && wr_ok) begin
      case (obj_index_i)
        `SSO_IDX_QSTOP:    qstop_code_reg <= obj_wdata_i[15:0];
        `SSO_IDX_SHUT:     shut_code_reg  <= obj_wdata_i[15:0];
        `SSO_IDX_DIS:      dis_code_reg   <= obj_wdata_i[15:0];
        `SSO_IDX_HALT:     halt_code_reg  <= obj_wdata_i[15:0];
        `SSO_IDX_FAULT:    fault_code_reg <= obj_wdata_i[15:0];
        `SSO_IDX_MODE_REQ: mode_req_reg   <= obj_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      obj_ack_o   <= 1'b0;
      obj_err_o   <= 1'b0;
      obj_rdata_o <= 32'h0000_0000;
    end else begin
      obj_ack_o   <= obj_req_i;
      obj_err_o   <= obj_req_i && (obj_we_i ? !wr_ok : !rd_hit);
      obj_rdata_o <= (obj_req_i && !obj_we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // positions and following error
  always_comb begin
    if (gear_ratio_i == 16'h0000) begin
      pos_user_next = enc_pos_i;
    end else begin
      pos_user_next = 32'($signed(enc_pos_i) /
                          $signed({16'h0000, gear_ratio_i}));
    end
    fe_diff = 33'($signed({pos_cmd_reg[31], pos_cmd_reg}) -
                  $signed({pos_user_reg[31], pos_user_reg}));
    fe_mag  = fe_diff[32] ? 33'(-fe_diff) : fe_diff;
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pos_cmd_reg       <= 32'h0000_0000;
      pos_enc_reg       <= 32'h0000_0000;
      pos_user_reg      <= 32'h0000_0000;
      fe_limit_reg      <= `SSO_FE_LIMIT_RST;
      following_error_o <= 1'b0;
    end else begin
      if (drive_enabled_i) begin
        pos_cmd_reg <= pos_cmd_i;
      end
      pos_enc_reg       <= enc_pos_i;
      pos_user_reg      <= pos_user_next;
      following_error_o <= drive_enabled_i &&
                           (fe_mag > {1'b0, fe_limit_reg});
    end
  end

endmodule

// ===== dv/sso_master_model.sv
module sso_master_model (
  input  wire logic [15:0] ctrl_word_i,
  output logic             quick_stop_o,
  output logic             halt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // quick stop bit is active low
  assign quick_stop_o = !ctrl_word_i[2];
  assign halt_o       = ctrl_word_i[8];
endmodule

// ===== dv/sso_stop_ctrl_props.sv
`include "sso_consts.svh"
module sso_stop_ctrl_props
  import sso_pkg::*;
#(parameter int SPD_W = 32) (
  input wire logic                 core_clk_i,
  input wire logic                 resetn_i,
  input wire logic                 obj_req_i,
  input wire logic                 obj_we_i,
  input wire logic [15:0]          obj_index_i,
  input wire logic [31:0]          obj_wdata_i,
  input wire logic                 obj_ack_o,
  input wire logic                 obj_err_o,
  input wire logic [31:0]          obj_rdata_o,
  input wire sso_pkg::sso_src_t    decel_src_o,
  input wire sso_pkg::sso_result_t end_state_o,
  input wire sso_pkg::sso_state_t  stop_state_o,
  input wire logic [SPD_W-1:0]     ramp_speed_o,
  input wire logic                 axis_enable_o,
  input wire logic                 coast_o,
  input wire logic                 torque_zero_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic wr, hold;
  assign wr = obj_req_i && obj_we_i;
  assign hold = stop_state_o == SSO_ST_HOLD;
  property p_ack; obj_req_i |=> obj_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_idle; !obj_req_i |=> !obj_ack_o && obj_rdata_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_mode; wr && obj_index_i == `SSO_IDX_MODE_REQ
    && obj_wdata_i[7:0] == 8'h02 |=> obj_err_o; endproperty
  a_mode: assert property (p_mode) else $error("mode 2 taken");
  property p_ro; wr && obj_index_i inside
    {[`SSO_IDX_POS_CMD:`SSO_IDX_FE_LIMIT]} |=> obj_err_o; endproperty
  a_ro: assert property (p_ro) else $error("ro write taken");
  property p_hold0; hold |-> ramp_speed_o == '0; endproperty
  a_hold0: assert property (p_hold0) else $error("hold speed");
  property p_mono; stop_state_o == SSO_ST_RAMP
    && $past(stop_state_o) == SSO_ST_RAMP
    |-> ramp_speed_o <= $past(ramp_speed_o); endproperty
  a_mono: assert property (p_mono) else $error("ramp rose");
  property p_open; hold && end_state_o inside {SSO_RES_OP_EN, SSO_RES_QSTOP}
    |-> axis_enable_o; endproperty
  a_open: assert property (p_open) else $error("axis off");
  property p_flt; hold && end_state_o inside {SSO_RES_FAULT, SSO_RES_SWON_DIS}
    |-> !axis_enable_o; endproperty
  a_flt: assert property (p_flt) else $error("axis on");
  property p_tz; torque_zero_o |-> decel_src_o == SSO_SRC_TZERO; endproperty
  a_tz: assert property (p_tz) else $error("zero torque src");
  property p_cst; coast_o |-> decel_src_o == SSO_SRC_COAST; endproperty
  a_cst: assert property (p_cst) else $error("coast src");
  c_halt: cover property (hold && end_state_o == SSO_RES_OP_EN);
  c_qs: cover property (hold && end_state_o == SSO_RES_QSTOP);
  c_flt: cover property (hold && end_state_o == SSO_RES_FAULT);
endmodule
bind sso_stop_ctrl sso_stop_ctrl_props #(.SPD_W(SPD_W)) u_props (.*);

// ===== dv/sso_stop_ctrl_test.sv
`include "sso_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module sso_stop_ctrl_test
  import sso_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, resetn_i, obj_req_i, obj_we_i, quick_stop_req_i;
  logic halt_req_i, shutdown_req_i, disable_req_i, fault_sel_i;
  logic fault_drive_i, alarm_coast_i, stop_method_param_i, release_i;
  logic drive_enabled_i, obj_ack_o, obj_err_o, axis_enable_o, coast_o;
  logic torque_zero_o, following_error_o, in_hold;
  logic [15:0] obj_index_i, gear_ratio_i, ctrl_word;
  logic [31:0] obj_wdata_i, obj_rdata_o, speed_cmd_i, pos_cmd_i, enc_pos_i;
  logic [31:0] profile_decel_i, quick_decel_i, third_decel_i, homing_acc_i;
  logic [31:0] torque_slope_i, ramp_speed_o;
  sso_src_t    decel_src_o;
  sso_result_t end_state_o;
  sso_state_t  stop_state_o;
  logic [32:0] oq [$];
  logic [7:0]  sq [$];
  logic [32:0] oe;
  logic [7:0]  se;
  int          checks, num_errors;
  logic [32:0] rv [12] = '{33'h2, 33'h0, 33'h0, 33'h1, 33'h0, 33'h1_0000_0000,
    33'h8, 33'h8, 33'h0, 33'h0, 33'h0, 33'h7530};
  logic [31:0] bad [15] = '{32'h605A0401, 32'h605A0801, 32'h605A0700,
    32'h605B0201, 32'h605C0201, 32'h605D0001, 32'h605D0401, 32'h605D0300,
    32'h605D0100, 32'h605E0301, 32'h60600201, 32'h60600B01, 32'h60610501,
    32'h60650001, 32'h60700001};
  logic [7:0]  md [7] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
  // mode,kind,code,aux,src,result (0 unchecked)
  logic [31:0] st [31] = '{32'h08010110, 32'h08020210, 32'h08030310,
    32'h08050120, 32'h08060220, 32'h03070320, 32'h01000610, 32'h06010410,
    32'h06050420, 32'h06020210, 32'h08101700, 32'h08110100, 32'h06110400,
    32'h0A110500, 32'h0A210500, 32'h09200600, 32'h08310130, 32'h09320230,
    32'h01330330, 32'h06310430, 32'h0A320530, 32'h0A330830, 32'h08401740,
    32'h08410140, 32'h03420240, 32'h06410440, 32'h06420240, 32'h0A410640,
    32'h0A420540, 32'h08520640, 32'h08620240};
  sso_stop_ctrl dut (.core_clk_i, .resetn_i, .obj_req_i, .obj_we_i,
    .obj_index_i, .obj_wdata_i, .quick_stop_req_i, .halt_req_i,
    .shutdown_req_i, .disable_req_i, .fault_sel_i, .fault_drive_i,
    .alarm_coast_i, .stop_method_param_i, .release_i, .drive_enabled_i,
    .speed_cmd_i, .profile_decel_i, .quick_decel_i, .third_decel_i,
    .homing_acc_i, .torque_slope_i, .pos_cmd_i, .enc_pos_i, .gear_ratio_i,
    .obj_ack_o, .obj_err_o, .obj_rdata_o, .decel_src_o, .end_state_o,
    .stop_state_o, .ramp_speed_o, .axis_enable_o, .coast_o, .torque_zero_o,
    .following_error_o);
  sso_master_model u_master (.ctrl_word_i(ctrl_word),
    .quick_stop_o(quick_stop_req_i), .halt_o(halt_req_i));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] i,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge core_clk_i);
    obj_req_i <= 1'b1;
    obj_we_i <= w;
    obj_index_i <= i;
    obj_wdata_i <= d;
    oq.push_back(e);
    @(posedge core_clk_i);
    obj_req_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] i, input logic [32:0] e);
    acc(1'b0, i, 32'h0, e);
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic r);
    acc(1'b1, i, d, {r, 32'h0});
  endtask
  task automatic wt(input sso_state_t s);
    int n;
    n = 0;
    while (stop_state_o !== s && n < 3000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 3000) num_errors++;
  endtask
  task automatic setmode(input logic [7:0] m);
    wr(`SSO_IDX_MODE_REQ, {24'h0, m}, 1'b0);
    repeat (6) @(posedge core_clk_i);
    wt(SSO_ST_IDLE);
    rd(`SSO_IDX_MODE_SHOW, {25'h0, m});
  endtask
  task automatic stop_case(input logic [31:0] t);
    logic [3:0] k;
    int s;
    k = t[23:20];
    s = $urandom_range(1023, 256);
    setmode(t[31:24]);
    wr(k > 4'h3 ? `SSO_IDX_FAULT : `SSO_IDX_QSTOP + {12'h0, k},
       {28'h0, t[19:16]}, 1'b0);
    @(posedge core_clk_i);
    alarm_coast_i <= t[12];
    stop_method_param_i <= t[12];
    speed_cmd_i <= s[0] ? -s : s;
    sq.push_back(t[11:4]);
    case (k)
      4'h0: ctrl_word <= 16'h0000;
      4'h1: shutdown_req_i <= 1'b1;
      4'h2: disable_req_i <= 1'b1;
      4'h4: fault_sel_i <= 1'b1;
      4'h5: fault_drive_i <= 1'b1;
      default: ctrl_word <= 16'h0104;
    endcase
    if (k == 4'h6) begin
      wt(SSO_ST_RAMP);
      fault_sel_i <= 1'b1;
    end
    wt(SSO_ST_HOLD);
    ctrl_word <= 16'h0004;
    {shutdown_req_i, disable_req_i, fault_sel_i, fault_drive_i} <= 4'h0;
    release_i <= (k != 4'h3);
    @(posedge core_clk_i);
    release_i <= 1'b0;
    wt(SSO_ST_IDLE);
  endtask
  always @(posedge core_clk_i) begin
    if (obj_ack_o === 1'b1) begin
      oe = oq.pop_front();
      `CHK("obj_err_o", oe[32], obj_err_o)
      `CHK("obj_rdata_o", oe[31:0], obj_rdata_o)
    end
    if (stop_state_o === SSO_ST_HOLD && in_hold !== 1'b1) begin
      se = sq.pop_front();
      `CHK("decel_src_o", se[7:4], decel_src_o)
      if (se[3:0] != 4'h0) `CHK("end_state_o", se[2:0], end_state_o)
    end
    in_hold <= (stop_state_o === SSO_ST_HOLD);
  end
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    #4000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    int s;
    {obj_req_i, obj_we_i, shutdown_req_i, disable_req_i} = 4'h0;
    {fault_sel_i, fault_drive_i, alarm_coast_i, stop_method_param_i} = 4'h0;
    {release_i, resetn_i, drive_enabled_i} = 3'b001;
    {ctrl_word, obj_index_i, gear_ratio_i} = {16'h0004, 16'h0, 16'h0004};
    {obj_wdata_i, speed_cmd_i, pos_cmd_i, enc_pos_i} = 128'h0;
    s = $urandom(32'h1D14);
    profile_decel_i = $urandom_range(31, 16);
    quick_decel_i = $urandom_range(31, 16);
    third_decel_i = $urandom_range(31, 16);
    homing_acc_i = $urandom_range(31, 16);
    torque_slope_i = $urandom_range(31, 16);
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < 12; i++) rd(`SSO_IDX_QSTOP + 16'(i), rv[i]);
    $display("reset values done");
    foreach (bad[j]) wr(bad[j][31:16], {24'h0, bad[j][15:8]}, bad[j][0]);
    rd(`SSO_IDX_HALT, 33'h1);
    $display("refusal done");
    foreach (md[j]) setmode(md[j]);
    $display("mode change done");
    s = $urandom_range(32'h00FF_FFFF, 0);
    enc_pos_i <= s;
    pos_cmd_i <= s / 4 + 30000;
    repeat (4) @(posedge core_clk_i);
    rd(`SSO_IDX_POS_ENC, {1'b0, 32'(s)});
    rd(`SSO_IDX_POS_USER, {1'b0, 32'(s / 4)});
    rd(`SSO_IDX_POS_CMD, {1'b0, 32'(s / 4 + 30000)});
    `CHK("following_error_o", 1'b0, following_error_o)
    pos_cmd_i <= s / 4 + 30001;
    repeat (4) @(posedge core_clk_i);
    `CHK("following_error_o", 1'b1, following_error_o)
    pos_cmd_i <= s / 4;
    $display("position done");
    foreach (st[j]) stop_case(st[j]);
    $display("stop reactions done");
    repeat (4) @(posedge core_clk_i);
    tally_and_finish();
  end
endmodule
